// file: sram_host_pkg.sv
package sram_host_pkg;

	// ************************************************************
	// Widths and timing
	// ************************************************************
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int CLK_PERIOD_NS = 25;
	localparam int WRITE_PULSE_MIN_NS = 8;
	localparam int ADDR_SETUP_MIN_NS = 0;
	localparam int WRITE_RECOVERY_MIN_NS = 0;
	localparam int SELECT_TO_WRITE_END_MIN_NS = 8;
	localparam int READ_ACCESS_MAX_NS = 12;
	// Least times round up and never fall below one cycle.
	localparam int WRITE_PULSE_CYC = ((WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1)
		? 1 : (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELECT_TO_END_CYC = ((SELECT_TO_WRITE_END_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS < 1) ? 1 : (SELECT_TO_WRITE_END_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC = ((READ_ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1)
		? 1 : (READ_ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] PULSE_COUNT = CNT_W'(WRITE_PULSE_CYC > SELECT_TO_END_CYC
		? WRITE_PULSE_CYC : SELECT_TO_END_CYC);
	localparam logic [CNT_W-1:0] READ_COUNT = CNT_W'(READ_CYC);
	// Read data passes two flip-flops before it is taken.
	localparam int SYNC_STAGES = 2;
	localparam logic [CNT_W-1:0] SYNC_COUNT = CNT_W'(SYNC_STAGES);

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_SETUP = 5'h02,
		ST_PULSE = 5'h04,
		ST_READ  = 5'h08,
		ST_END   = 5'h10
	} state_t;

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0]        lanes;
	} request_t;

	typedef struct packed {
		logic              chip_select_n;
		logic              output_enable_n;
		logic              write_enable_n;
		logic              low_lane_select_n;
		logic              high_lane_select_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data_out;
		logic              data_oe_n;
	} pins_t;

	// Pin values after reset: every strobe high and the data drivers off.
	localparam pins_t PINS_IDLE = '{
		chip_select_n: 1'b1, output_enable_n: 1'b1, write_enable_n: 1'b1,
		low_lane_select_n: 1'b1, high_lane_select_n: 1'b1,
		addr: '0, data_out: '0, data_oe_n: 1'b1};

	typedef struct packed {
		state_t            state;
		logic [CNT_W-1:0]  count;
		request_t          req;
		pins_t             pins;
		logic              busy;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] sync1;
		logic [DATA_W-1:0] sync2;
	} regs_t;

endpackage : sram_host_pkg

// file: sram_host.sv
// Notes on behaviour
// - Address changes only with enable or select high.
// - Never drive data while memory reads out.
// - Address settled before window opens.
// - Address held until window closes.
// - Select low long enough before write end.
`timescale 1ns/1ps
module sram_host (
	// Clock and reset
	input  wire logic                              clk,
	input  wire logic                              reset,
	input  wire logic                              clk_en,
	// Request side
	input  wire logic                              req_valid,
	input  wire sram_host_pkg::request_t           req,
	output logic                                   busy,
	output logic                                   rvalid,
	output logic [sram_host_pkg::DATA_W-1:0]       rdata,
	// Memory pins
	output sram_host_pkg::pins_t                   pins,
	input  wire logic [sram_host_pkg::DATA_W-1:0]  data_in
);

	// ************************************************************
	// State
	// ************************************************************
	sram_host_pkg::regs_t r;
	sram_host_pkg::regs_t next_r;

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		next_r = r;
		next_r.rvalid = 1'b0;
		next_r.sync1 = data_in;
		next_r.sync2 = r.sync1;
		case (r.state)
			sram_host_pkg::ST_IDLE: begin
				// Requests made while busy are dropped without notice.
				next_r.busy = 1'b0;
				if (req_valid) begin
					// Address moves while every strobe is high.
					next_r.req = req;
					next_r.pins.addr = req.addr;
					next_r.busy = 1'b1;
					next_r.state = sram_host_pkg::ST_SETUP;
				end
			end
			sram_host_pkg::ST_SETUP: begin
				// Select, the requested lane selects and the access strobe fall together, so the window opens on this edge.
				next_r.pins.chip_select_n = 1'b0;
				// Lower lane is bits 7:0, upper lane bits 15:8.
				next_r.pins.low_lane_select_n = ~r.req.lanes[0];
				next_r.pins.high_lane_select_n = ~r.req.lanes[1];
				next_r.count = '0;
				if (r.req.write) begin
					// Output enable stays high so the memory never drives.
					next_r.pins.write_enable_n = 1'b0;
					next_r.pins.data_out = r.req.wdata;
					next_r.pins.data_oe_n = 1'b0;
					next_r.state = sram_host_pkg::ST_PULSE;
				end else begin
					// Our drivers are off while the memory reads out.
					next_r.pins.output_enable_n = 1'b0;
					next_r.pins.data_oe_n = 1'b1;
					next_r.state = sram_host_pkg::ST_READ;
				end
			end
			sram_host_pkg::ST_PULSE: begin
				next_r.count = r.count + 1'b1;
				// Pulse and select held for the minimum width.
				if (r.count + 1'b1 >= sram_host_pkg::PULSE_COUNT) begin
					// Write enable rises first and closes the window.
					next_r.pins.write_enable_n = 1'b1;
					next_r.state = sram_host_pkg::ST_END;
				end
			end
			sram_host_pkg::ST_READ: begin
				next_r.count = r.count + 1'b1;
				// Two extra cycles let the synchroniser settle.
				if (r.count >= sram_host_pkg::READ_COUNT + sram_host_pkg::SYNC_COUNT) begin
					next_r.rdata = r.sync2;
					next_r.rvalid = 1'b1;
					next_r.pins.output_enable_n = 1'b1;
					next_r.state = sram_host_pkg::ST_END;
				end
			end
			sram_host_pkg::ST_END: begin
				// Address and data held past the closing edge.
				next_r.pins.chip_select_n = 1'b1;
				next_r.pins.low_lane_select_n = 1'b1;
				next_r.pins.high_lane_select_n = 1'b1;
				next_r.pins.data_oe_n = 1'b1;
				next_r.busy = 1'b0;
				next_r.state = sram_host_pkg::ST_IDLE;
			end
			default: begin
				next_r.state = sram_host_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			// Reset parks every strobe high so the memory stays in standby.
			r.state <= sram_host_pkg::ST_IDLE;
			r.count <= '0;
			r.req <= '0;
			r.pins <= sram_host_pkg::PINS_IDLE;
			r.busy <= 1'b0;
			r.rvalid <= 1'b0;
			r.rdata <= '0;
			r.sync1 <= '0;
			r.sync2 <= '0;
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	assign busy = r.busy;
	assign rvalid = r.rvalid;
	assign rdata = r.rdata;
	assign pins = r.pins;

	// ************************************************************
	// Checks
	// ************************************************************
	// Checks step only on enabled edges, since a frozen cycle changes nothing.
	default clocking cb @(posedge clk iff clk_en); endclocking
	default disable iff (reset);

	// Window events as they appear at the pins.
	sequence s_pulse_open;
		$fell(pins.write_enable_n);
	endsequence

	sequence s_window_close;
		$rose(pins.write_enable_n);
	endsequence

	sequence s_read_open;
		$fell(pins.output_enable_n);
	endsequence

	a_addr_stable: assert property ($changed(pins.addr) |->
		pins.write_enable_n || pins.chip_select_n)
		else $error("address changed inside a write window");
	a_pulse_width: assert property (s_pulse_open |->
		!pins.write_enable_n [*1] ##1 pins.write_enable_n)
		else $error("write pulse has the wrong width");
	a_select_held: assert property (s_pulse_open |->
		!pins.chip_select_n [*2])
		else $error("chip select rose before write end");
	a_no_contention: assert property (!pins.output_enable_n |->
		pins.data_oe_n)
		else $error("data driven while memory reads out");
	a_oe_in_write: assert property (!pins.write_enable_n |->
		pins.output_enable_n && !pins.data_oe_n)
		else $error("output enable low during write");
	a_addr_hold: assert property ($rose(pins.write_enable_n) |->
		$stable(pins.addr) && $stable(pins.data_out))
		else $error("address moved at window close");
	a_open_together: assert property (s_pulse_open |->
		$fell(pins.chip_select_n))
		else $error("write strobes did not fall together");
	a_close_first: assert property ($rose(pins.write_enable_n) |->
		!pins.chip_select_n ##1 pins.chip_select_n)
		else $error("write enable did not close the window first");
	a_read_lanes: assert property ($fell(pins.output_enable_n) |->
		pins.write_enable_n && (pins.low_lane_select_n == ~r.req.lanes[0]))
		else $error("read strobes wrong");
	a_addr_setup: assert property (s_pulse_open |-> $stable(pins.addr))
		else $error("address moved as window opened");

	// ************************************************************
	// Sequence checks
	// ************************************************************
	// Each access is followed strobe by strobe; lane selects, and for writes address and data, are checked against r.req.
	a_idle_strobes: assert property (!busy |->
		pins.chip_select_n && pins.write_enable_n && pins.output_enable_n)
		else $error("strobes active while idle");
	a_busy_end: assert property ($fell(busy) |->
		pins.chip_select_n && pins.data_oe_n)
		else $error("busy fell with the memory still selected");
	a_data_hold: assert property (s_window_close |-> !pins.data_oe_n)
		else $error("write data released before window close");
	a_read_float: assert property (s_read_open |->
		pins.data_oe_n && !pins.chip_select_n)
		else $error("read opened with data drivers on");
	a_oe_close: assert property ($rose(pins.output_enable_n) |->
		!pins.chip_select_n ##1 pins.chip_select_n)
		else $error("select rose before output enable");
	a_lanes_open: assert property ($fell(pins.chip_select_n) |->
		pins.high_lane_select_n == ~r.req.lanes[1] &&
		pins.low_lane_select_n == ~r.req.lanes[0])
		else $error("lane selects do not match the request");
	a_addr_open: assert property (s_pulse_open |-> pins.addr == r.req.addr)
		else $error("wrong address at window open");
	a_write_data: assert property (s_pulse_open |->
		pins.data_out == r.req.wdata)
		else $error("wrong write data at window open");
	a_read_answer: assert property (s_read_open |-> ##4 rvalid)
		else $error("read data not handed over in time");
	a_strobes_together: assert property ($fell(pins.chip_select_n) |->
		!pins.write_enable_n || !pins.output_enable_n)
		else $error("select fell without its access strobe");

endmodule : sram_host

// file: sram_model.sv
`timescale 1ns/1ps
module sram_model (
	// Strobes
	input  wire logic                             cs_n,
	input  wire logic                             oe_n,
	input  wire logic                             we_n,
	input  wire logic                             low_lane_select_n,
	input  wire logic                             high_lane_select_n,
	// Address and data
	input  wire logic [sram_host_pkg::ADDR_W-1:0] addr,
	input  wire logic [15:0]                      din,
	output logic      [15:0]                      dout,
	output logic      [1:0]                       drv
);
	logic [15:0] mem [256];
	wire         rd = !cs_n && !oe_n && we_n;
	assign drv  = {2{rd}} & ~{high_lane_select_n, low_lane_select_n};
	assign dout = mem[addr[7:0]];
	initial foreach (mem[i]) mem[i] = 16'h0000;
	// Storage follows the strobe overlap directly, so the window opens and shuts with it.
	always @* begin
		if (!cs_n && !we_n && !low_lane_select_n) mem[addr[7:0]][7:0] = din[7:0];
		if (!cs_n && !we_n && !high_lane_select_n) mem[addr[7:0]][15:8] = din[15:8];
	end
endmodule : sram_model

// file: test_sram_host.sv
`timescale 1ns/1ps
module test_sram_host;
	logic                  clk = 0, reset = 1, req_valid = 0, busy, rvalid, last_act = 0;
	logic [15:0]           rdata, mdout, q;
	wire  [15:0]           data_in;
	logic [1:0]            mdrv;
	logic [7:0]            flt = 8'h00;
	logic [17:0]           last_addr = '0;
	sram_host_pkg::request_t req = '0;
	sram_host_pkg::pins_t  pins;
	int                    bad_count = 0, n_tests = 0, cycles = 0;
	always #12.5 clk = ~clk;
	sram_host uut (.clk(clk), .reset(reset), .clk_en(1'b1), .req_valid(req_valid),
		.req(req), .busy(busy), .rvalid(rvalid), .rdata(rdata), .pins(pins), .data_in(data_in));
	sram_model mem_dev (.cs_n(pins.chip_select_n), .oe_n(pins.output_enable_n),
		.we_n(pins.write_enable_n), .low_lane_select_n(pins.low_lane_select_n),
		.high_lane_select_n(pins.high_lane_select_n), .addr(pins.addr), .din(data_in),
		.dout(mdout), .drv(mdrv));
	// Bytes nobody drives carry a changing pattern.
	assign data_in[7:0]  = !pins.data_oe_n ? pins.data_out[7:0] : mdrv[0] ? mdout[7:0] : flt;
	assign data_in[15:8] = !pins.data_oe_n ? pins.data_out[15:8] : mdrv[1] ? mdout[15:8] : ~flt;
	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic end_of_test;
		$display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	always @(negedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			bad_count++;
			end_of_test();
		end
	end
	always @(negedge clk) begin
		flt <= flt + 8'h3b;
		if (!reset) begin
			chk("addr_stable", 16'h1, 16'(pins.addr === last_addr || !last_act));
			chk("no_contention", 16'h1, 16'(pins.data_oe_n | ~|mdrv));
		end
		last_addr <= pins.addr;
		last_act  <= !pins.chip_select_n && !pins.write_enable_n;
	end
	task automatic op(logic w, logic [17:0] a, logic [15:0] d, logic [1:0] l,
		output logic [15:0] r);
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 50) begin
			@(negedge clk);
			n++;
		end
		req_valid = 1;
		req = '{w, a, d, l};
		@(negedge clk);
		req_valid = 0;
		chk("busy_taken", 16'h1, 16'(busy));
		@(negedge clk);
		n = 0;
		while (!w && rvalid !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (!w) chk("read_valid", 16'h1, 16'(rvalid));
		r = w ? 16'h0000 : rdata;
		while (busy !== 1'b0 && n < 50) begin
			@(negedge clk);
			n++;
		end
		chk("busy_idle", 16'h0, 16'(busy));
	endtask : op
	task automatic t_full;
		op(1, 18'h00012, 16'ha5c3, 2'h3, q);
		op(0, 18'h00012, 16'h0000, 2'h3, q);
		chk("full_word", 16'ha5c3, q);
	endtask : t_full
	task automatic t_lanes;
		op(1, 18'h00012, 16'h1177, 2'h1, q);
		op(1, 18'h00012, 16'h88ff, 2'h2, q);
		op(1, 18'h00012, 16'hffff, 2'h0, q);
		op(0, 18'h00012, 16'h0000, 2'h3, q);
		chk("lane_merge", 16'h8877, q);
		op(0, 18'h00012, 16'h0000, 2'h1, q);
		chk("low_read", 16'h0077, {8'h00, q[7:0]});
	endtask : t_lanes
	task automatic t_refuse;
		req = '{1'b1, 18'h00056, 16'h1234, 2'h3};
		req_valid = 1;
		@(negedge clk);
		req = '{1'b1, 18'h00034, 16'hdead, 2'h3};
		@(negedge clk);
		req_valid = 0;
		op(0, 18'h00034, 16'h0000, 2'h3, q);
		chk("refused", 16'h0000, q);
		op(0, 18'h00056, 16'h0000, 2'h3, q);
		chk("taken", 16'h1234, q);
	endtask : t_refuse
	initial begin
		repeat (6) @(negedge clk);
		reset = 0;
		t_full();
		t_lanes();
		t_refuse();
		end_of_test();
	end
endmodule : test_sram_host
